/* File: logic/pps_pkg.sv */
package pps_pkg;
    // System and shift clock rates
    localparam int unsigned SYS_HZ = 20_000_000;
    localparam int unsigned SHIFT_HZ = 10_000_000;
    // Shift clock high and low time in system cycles
    localparam int unsigned HALF_CYC = SYS_HZ / SHIFT_HZ / 2;
    // Pulses per transfer and pulse counter width
    localparam int unsigned SHIFT_PULSES = 16;
    localparam int unsigned CNT_W = 4;
    // Delay from strobe trailing edge to first shift pulse
    localparam int unsigned START_DLY_NS = 100;
    localparam int unsigned START_DLY_CYC = (START_DLY_NS * (SYS_HZ / 1_000_000) + 999) / 1000;
    // Gap from last shift pulse to control latch load
    localparam int unsigned LATCH_DLY_NS = 100;
    localparam int unsigned LATCH_DLY_CYC = (LATCH_DLY_NS * (SYS_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned DLY_W = 4;
    // Word widths
    localparam int unsigned CTRL_W = 8;
    localparam int unsigned DATA_W = 16;
    // Start select bit positions
    localparam int unsigned START_CTRL_BIT = 0;
    localparam int unsigned START_DATA_BIT = 1;
    // Reset value of the control latch
    localparam logic [7:0] CTRL_LATCH_RST = 8'h00;

    // Output enables of the four open-collector flag lines
    typedef struct packed {
        logic abnormal;
        logic curlim;
        logic pwroff;
        logic not_ready;
    } flags_s;

    // Serial link toward the isolated side
    typedef struct packed {
        logic sclk;
        logic sdata_ctrl;
        logic sdata_data;
    } serial_s;
endpackage

/* File: logic/program_serializer.sv */
`timescale 1ns/1ns
module program_serializer
#(
    parameter int unsigned CTRL_W = pps_pkg::CTRL_W,
    parameter int unsigned DATA_W = pps_pkg::DATA_W
)
(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic srst_i,
    input wire logic [CTRL_W-1:0] ctrl_word_i,
    input wire logic [DATA_W-1:0] data_word_i,
    input wire logic ctrl_strobe_i,
    input wire logic data_strobe_i,
    input wire logic strobe_sel_i,
    input wire logic dual_mode_i,
    input wire logic addr_i,
    input wire logic [1:0] start_sel_i,
    input wire logic negative_i,
    input wire logic poll_n_i,
    input wire logic overload_i,
    input wire logic power_fail_i,
    output logic [CTRL_W-1:0] ctrl_thru_o,
    output logic [DATA_W-1:0] data_thru_o,
    output pps_pkg::serial_s serial_o,
    output logic first_hold_o,
    output logic hold_o,
    output logic latch_load_o,
    output logic [CTRL_W-1:0] ctrl_latch_o,
    output logic [DATA_W-1:0] data_par_o,
    output pps_pkg::flags_s flag_out_o,
    output pps_pkg::flags_s flag_oe_o
);
    typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_DELAY, ST_SHIFT, ST_LATCH} xfer_e;

    logic [1:0] rst_sync_r;
    logic rst_n;
    // Reset release through two flops, assertion stays asynchronous
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // All pin inputs pass two flops; first stage is read by the second only
    localparam int unsigned SW = CTRL_W + DATA_W + 12;
    logic [SW-1:0] pin_raw, pin_m_r, pin_s_r;
    assign pin_raw = {ctrl_word_i, data_word_i, ctrl_strobe_i, data_strobe_i, strobe_sel_i,
                      dual_mode_i, addr_i, start_sel_i, negative_i, poll_n_i, overload_i,
                      power_fail_i, srst_i};
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_m_r <= '0;
            pin_s_r <= '0;
        end
        else
        begin
            pin_m_r <= pin_raw;
            pin_s_r <= pin_m_r;
        end
    end

    logic [CTRL_W-1:0] ctrl_s;
    logic [DATA_W-1:0] data_s;
    logic cstb_s, dstb_s, sel_s, dual_s, addr_s, neg_s, poll_n_s, ovl_s, pfail_s, srst_s;
    logic [1:0] start_s;
    assign {ctrl_s, data_s, cstb_s, dstb_s, sel_s, dual_s, addr_s, start_s, neg_s,
            poll_n_s, ovl_s, pfail_s, srst_s} = pin_s_r;

    // Strobe edge detection on the synchronised copies
    logic cstb_d_r, dstb_d_r;
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cstb_d_r <= 1'b0;
            dstb_d_r <= 1'b0;
        end
        else
        begin
            cstb_d_r <= cstb_s;
            dstb_d_r <= dstb_s;
        end
    end
    wire cstb_rise = cstb_s & ~cstb_d_r;
    wire dstb_rise = dstb_s & ~dstb_d_r;
    wire cstb_fall = ~cstb_s & cstb_d_r;
    wire dstb_fall = ~dstb_s & dstb_d_r;

    // Load steering; an unaddressed unit loads on no strobe
    wire ld_ctrl = addr_s & cstb_rise & (dual_s | sel_s);
    wire ld_data = addr_s & (dual_s ? dstb_rise : (cstb_rise & ~sel_s));
    wire ld_any = ld_ctrl | ld_data;
    // Trailing edge of a strobe chosen to start the transfer
    wire start_edge = (start_s[pps_pkg::START_CTRL_BIT] & cstb_fall)
                    | (start_s[pps_pkg::START_DATA_BIT] & dstb_fall);

    xfer_e st_r, st_nxt;
    logic [pps_pkg::DLY_W-1:0] dly_r;
    logic [pps_pkg::CNT_W-1:0] cnt_r;
    logic phase_r;
    logic cmp_r;
    logic hold_r;
    logic first_hold_r;
    logic [CTRL_W-1:0] ctrl_sr_r, rx_ctrl_r, ctrl_latch_r;
    logic [DATA_W-1:0] data_sr_r, rx_data_r;

    // A pulse ends on the falling half of the shift clock
    wire pulse_end = (st_r == ST_SHIFT) & phase_r;
    wire carry = pulse_end & (cnt_r == pps_pkg::CNT_W'(pps_pkg::SHIFT_PULSES - 1));
    wire dly_done = dly_r == '0;
    wire sdata_data = data_sr_r[0] ^ (cmp_r & neg_s);
    wire sdata_ctrl = ctrl_sr_r[0];

    // Transfer sequencing
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE:
                if (ld_any)
                    st_nxt = ST_ARMED;
            ST_ARMED:
                if (start_edge)
                    st_nxt = ST_DELAY;
            ST_DELAY:
                if (dly_done)
                    st_nxt = ST_SHIFT;
            ST_SHIFT:
                if (carry)
                    st_nxt = ST_LATCH;
            ST_LATCH:
                if (dly_done)
                    st_nxt = ST_IDLE;
            default:
                st_nxt = ST_IDLE;
        endcase
    end

    // State, delay counter and shift clock phase
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= ST_IDLE;
            dly_r <= '0;
            phase_r <= 1'b0;
        end
        else if (srst_s)
        begin
            st_r <= ST_IDLE;
            dly_r <= '0;
            phase_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            if (st_r == ST_ARMED)
                dly_r <= pps_pkg::DLY_W'(pps_pkg::START_DLY_CYC - 1);
            else if (st_r == ST_SHIFT)
                dly_r <= pps_pkg::DLY_W'(pps_pkg::LATCH_DLY_CYC - 1);
            else if (!dly_done)
                dly_r <= dly_r - 1'b1;
            // 20 MHz toggling gives a 10 MHz shift clock
            phase_r <= (st_nxt == ST_SHIFT) ? ~phase_r : 1'b0;
        end
    end

    // Pulse counter and complement flop; the carry clears both
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= '0;
            cmp_r <= 1'b0;
        end
        else if (srst_s | carry)
        begin
            cnt_r <= '0;
            cmp_r <= 1'b0;
        end
        else if (pulse_end)
        begin
            cnt_r <= cnt_r + 1'b1;
            if (data_sr_r[0])
                cmp_r <= 1'b1;
        end
    end

    // Hold spans from load to the carry; first hold marks the load itself
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_r <= 1'b0;
            first_hold_r <= 1'b0;
        end
        else if (srst_s)
        begin
            hold_r <= 1'b0;
            first_hold_r <= 1'b0;
        end
        else
        begin
            first_hold_r <= ld_any;
            if (carry)
                hold_r <= 1'b0;
            else if (first_hold_r)
                hold_r <= 1'b1;
        end
    end

    // Send side registers: parallel load, then rotate; control word goes round twice
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_sr_r <= '0;
            data_sr_r <= '0;
        end
        else if (pulse_end)
        begin
            ctrl_sr_r <= {ctrl_sr_r[0], ctrl_sr_r[CTRL_W-1:1]};
            data_sr_r <= {data_sr_r[0], data_sr_r[DATA_W-1:1]};
        end
        else
        begin
            if (ld_ctrl)
                ctrl_sr_r <= ctrl_s;
            if (ld_data)
                data_sr_r <= data_s;
        end
    end

    // Receive side reassembles words on the forwarded clock
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_ctrl_r <= '0;
            rx_data_r <= '0;
        end
        else if (pulse_end)
        begin
            rx_ctrl_r <= {sdata_ctrl, rx_ctrl_r[CTRL_W-1:1]};
            rx_data_r <= {sdata_data, rx_data_r[DATA_W-1:1]};
        end
    end

    // Control latch loads once the gap after the last pulse runs out
    wire latch_load = (st_r == ST_LATCH) & dly_done;
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_latch_r <= pps_pkg::CTRL_LATCH_RST;
        else if (latch_load)
            ctrl_latch_r <= rx_ctrl_r;
    end

    // Pass-through words for the next unit in the chain
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_thru_o <= '0;
            data_thru_o <= '0;
        end
        else
        begin
            ctrl_thru_o <= ctrl_s;
            data_thru_o <= data_s;
        end
    end

    // Open-collector flags only ever pull low; the source supplies pull-ups
    pps_pkg::flags_s flag_oe_nxt, flag_oe_r;
    assign flag_oe_nxt.abnormal = ovl_s | pfail_s;
    assign flag_oe_nxt.curlim = ~poll_n_s & ovl_s;
    assign flag_oe_nxt.pwroff = ~poll_n_s & pfail_s;
    assign flag_oe_nxt.not_ready = (st_r != ST_IDLE) | hold_r | first_hold_r;
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            flag_oe_r <= '0;
        else
            flag_oe_r <= flag_oe_nxt;
    end

    // Output drive
    assign flag_oe_o = flag_oe_r;
    assign flag_out_o = '0;
    assign serial_o.sclk = phase_r;
    assign serial_o.sdata_ctrl = sdata_ctrl;
    assign serial_o.sdata_data = sdata_data;
    assign first_hold_o = first_hold_r;
    assign hold_o = hold_r;
    assign latch_load_o = latch_load;
    assign ctrl_latch_o = ctrl_latch_r;
    assign data_par_o = rx_data_r;

    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n);

    logic [4:0] seen_r;
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            seen_r <= '0;
        else if (st_r != ST_SHIFT)
            seen_r <= '0;
        else if (pulse_end)
            seen_r <= seen_r + 1'b1;
    end

    // Control word as last loaded; the far side must rebuild it unaltered
    logic [CTRL_W-1:0] ctrl_ld_r;
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_ld_r <= '0;
        else if (ld_ctrl & ~pulse_end)
            ctrl_ld_r <= ctrl_s;
    end

    sequence pulse_s;
        serial_o.sclk ##1 !serial_o.sclk;
    endsequence
    sequence hold_begin_s;
        first_hold_o ##1 hold_o;
    endsequence

    hold_whole_xfer_a: assert property (st_r == ST_SHIFT |-> hold_o)
        else $error("hold low during shifting");
    // A synchronous clear cuts a transfer short, so only a finished one is counted
    sixteen_pulses_a: assert property ($fell(st_r == ST_SHIFT) && st_r == ST_LATCH |-> seen_r == 5'h10)
        else $error("transfer pulse count not sixteen");
    clock_stopped_a: assert property (st_r != ST_SHIFT |-> !serial_o.sclk)
        else $error("shift clock runs outside transfer");
    shift_clock_rate_a: assert property ($rose(serial_o.sclk) |-> pulse_s)
        else $error("shift pulse not one cycle high");
    latch_after_hold_a: assert property (latch_load_o |-> !hold_o && $past(!hold_o))
        else $error("latch load while hold active");
    unaddressed_ignore_a: assert property (!addr_s |-> !ld_ctrl && !ld_data)
        else $error("load while unaddressed");
    dual_routing_a: assert property (dual_s && addr_s && cstb_rise |-> ld_ctrl && !ld_data)
        else $error("dual mode control strobe misrouted");
    single_routing_a: assert property (!dual_s && addr_s && cstb_rise && !sel_s |-> ld_data && !ld_ctrl)
        else $error("single mode strobe misrouted");
    hold_follows_load_a: assert property (ld_any && !srst_s |=> hold_begin_s)
        else $error("load did not raise hold");
    not_ready_busy_a: assert property (hold_o |=> flag_oe_o.not_ready)
        else $error("not ready missing while busy");
    ctrl_uncomplemented_a: assert property (latch_load_o |-> rx_ctrl_r == ctrl_ld_r)
        else $error("control word altered");
    poll_current_a: assert property (!poll_n_s && ovl_s |=> flag_oe_o.curlim)
        else $error("polled overload not flagged");
    start_delay_a: assert property ($rose(st_r == ST_DELAY) |-> ##[1:4] st_r == ST_SHIFT)
        else $error("transfer start delay wrong");
endmodule

/* File: tb/src_model.sv */
`timescale 1ns/1ns
// Program source side: strobes the unit and pulls the flag bus up
module src_model
(
    input wire logic clk_i,
    input wire logic addr_i,
    input wire logic dual_i,
    input wire pps_pkg::flags_s flag_oe_i,
    output logic ctrl_strobe_o,
    output logic data_strobe_o,
    output logic strobe_sel_o,
    output logic poll_n_o,
    output pps_pkg::flags_s flag_line_o
);
    // Pull-ups: a released line reads high, a driven one low
    assign flag_line_o = pps_pkg::flags_s'(~flag_oe_i);
    // Poll wired to this unit's own address line, never bussed
    assign poll_n_o = ~addr_i;

    initial
    begin
        ctrl_strobe_o = 1'b0;
        data_strobe_o = 1'b0;
        strobe_sel_o = 1'b0;
    end

    // One load strobe; long and spaced so the synchronisers see it whole
    task automatic load(input logic is_ctrl);
        strobe_sel_o <= is_ctrl;
        repeat (3) @(posedge clk_i);
        if (dual_i && !is_ctrl)
            data_strobe_o <= 1'b1;
        else
            ctrl_strobe_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        ctrl_strobe_o <= 1'b0;
        data_strobe_o <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    typedef struct packed {
        logic dual;
        logic cfirst;
        logic [1:0] st;
        logic neg;
        logic [7:0] cw;
        logic [15:0] dw;
    } row_s;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic srst = 1'b0;
    logic [7:0] cw = 8'h00;
    logic [15:0] dw = 16'h0000;
    logic cs, ds, ssel, poll_n;
    logic dual = 1'b1;
    logic addr = 1'b1;
    logic [1:0] start = 2'b00;
    logic neg = 1'b0;
    logic ovl = 1'b0;
    logic pfail = 1'b0;
    logic [7:0] cthru, clat;
    logic [15:0] dthru, dpar;
    pps_pkg::serial_s ser;
    logic fh, hold, ll, sclk_q;
    pps_pkg::flags_s fout, foe, line;
    int fail_count = 0;
    int samples_checked = 0;
    int sclk_n, fh_n, snap;
    logic hold_gap;
    row_s rows [5] = '{
        '{1'b1, 1'b1, 2'b10, 1'b0, 8'ha5, 16'h1234},
        '{1'b1, 1'b0, 2'b01, 1'b1, 8'h81, 16'h00f0},
        '{1'b0, 1'b1, 2'b01, 1'b0, 8'h7e, 16'hbeef},
        '{1'b0, 1'b0, 2'b01, 1'b1, 8'hff, 16'h0001},
        '{1'b1, 1'b1, 2'b11, 1'b1, 8'h00, 16'h8000}};

    always #25 clk = ~clk;

    program_serializer dut (.clk_sys_i(clk), .nrst_i(nrst), .srst_i(srst), .ctrl_word_i(cw),
        .data_word_i(dw), .ctrl_strobe_i(cs), .data_strobe_i(ds), .strobe_sel_i(ssel),
        .dual_mode_i(dual), .addr_i(addr), .start_sel_i(start), .negative_i(neg),
        .poll_n_i(poll_n), .overload_i(ovl), .power_fail_i(pfail), .ctrl_thru_o(cthru),
        .data_thru_o(dthru), .serial_o(ser), .first_hold_o(fh), .hold_o(hold),
        .latch_load_o(ll), .ctrl_latch_o(clat), .data_par_o(dpar), .flag_out_o(fout),
        .flag_oe_o(foe));
    src_model src (.clk_i(clk), .addr_i(addr), .dual_i(dual), .flag_oe_i(foe),
        .ctrl_strobe_o(cs), .data_strobe_o(ds), .strobe_sel_o(ssel), .poll_n_o(poll_n),
        .flag_line_o(line));

    // Shift pulses, first-hold pulses and any pulse seen without hold
    always @(posedge clk)
    begin
        sclk_q <= ser.sclk;
        if (ser.sclk && !sclk_q)
            sclk_n++;
        if (ser.sclk && !hold)
            hold_gap = 1'b1;
        if (fh)
            fh_n++;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
            fail_count++;
        end
    endtask

    task automatic conclude();
        if (fail_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Bounded wait: 0 for the latch pulse, 1 for not-ready released
    task automatic wait_for(input int which);
        int i;
        for (i = 0; i < 400; i++)
        begin
            @(posedge clk);
            if (which == 0 ? ll === 1'b1 : line.not_ready === 1'b1)
                return;
        end
        fail_count++;
        conclude();
    endtask

    // Two loads, the second one's trailing edge starts the transfer
    task automatic run(input row_s r);
        logic [15:0] exp;
        exp = r.neg ? 16'(~r.dw + 16'h0001) : r.dw;
        dual <= r.dual;
        neg <= r.neg;
        cw <= r.cw;
        dw <= r.dw;
        start <= 2'b00;
        repeat (4) @(posedge clk);
        sclk_n = 0;
        fh_n = 0;
        hold_gap = 1'b0;
        src.load(r.cfirst);
        start <= r.st;
        src.load(!r.cfirst);
        chk("not_ready", line.not_ready, 0);
        chk("ctrl_thru", cthru, r.cw);
        chk("data_thru", dthru, r.dw);
        wait_for(0);
        chk("hold_at_load", hold, 0);
        chk("first_holds", fh_n, 2);
        chk("hold_gap", hold_gap, 0);
        repeat (2) @(posedge clk);
        chk("ctrl_latch", clat, r.cw);
        chk("data_par", dpar, exp);
        wait_for(1);
        chk("pulses", sclk_n, 16);
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        // Everything quiet while reset is held
        chk("rst_hold", hold, 0);
        chk("rst_latch", clat, pps_pkg::CTRL_LATCH_RST);
        chk("rst_oe", foe, 0);
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (8) @(posedge clk);
        foreach (rows[k])
            run(rows[k]);
        // Strobe while unaddressed must be ignored
        addr <= 1'b0;
        fh_n = 0;
        src.load(1'b1);
        repeat (6) @(posedge clk);
        chk("unaddr_fh", fh_n, 0);
        chk("unaddr_nr", line.not_ready, 1);
        // Abnormal line acts as interrupt, then the unit is polled
        ovl <= 1'b1;
        repeat (6) @(posedge clk);
        chk("abn_ovl", line.abnormal, 0);
        chk("unpolled_cl", line.curlim, 1);
        addr <= 1'b1;
        repeat (6) @(posedge clk);
        chk("polled_cl", line.curlim, 0);
        chk("polled_po_ok", line.pwroff, 1);
        ovl <= 1'b0;
        pfail <= 1'b1;
        repeat (6) @(posedge clk);
        chk("polled_po", line.pwroff, 0);
        chk("cl_clear", line.curlim, 1);
        chk("abn_pf", line.abnormal, 0);
        pfail <= 1'b0;
        repeat (6) @(posedge clk);
        chk("abn_idle", line.abnormal, 1);
        chk("flag_out", fout, 0);
        // Synchronous clear in mid-transfer
        dual <= 1'b1;
        start <= 2'b01;
        cw <= 8'h5a;
        repeat (4) @(posedge clk);
        src.load(1'b1);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(posedge clk);
        chk("srst_hold", hold, 0);
        snap = sclk_n;
        repeat (40) @(posedge clk);
        chk("srst_clk", sclk_n, snap);
        chk("srst_latch", clat, rows[4].cw);
        run(rows[1]);
        // Asynchronous reset in mid-transfer clears state and the latch
        cw <= 8'h3c;
        repeat (4) @(posedge clk);
        src.load(1'b1);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("mid_rst_hold", hold, 0);
        chk("mid_rst_latch", clat, pps_pkg::CTRL_LATCH_RST);
        chk("mid_rst_oe", foe, 0);
        chk("mid_rst_clk", ser.sclk, 0);
        repeat (18) @(posedge clk);
        nrst <= 1'b1;
        // Let reset release and the pin synchronisers settle before the next strobe
        repeat (8) @(posedge clk);
        run(rows[0]);
        conclude();
    end
endmodule
